// file: src/lcgs_top.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
module lcgs_top #(
    parameter int NUM_GATES = lcgs_pkg::NUM_GATES,
    parameter int NUM_DATA = lcgs_pkg::NUM_DATA,
    parameter int NUM_SRC = lcgs_pkg::NUM_SRC,
    parameter int SEL_W = lcgs_pkg::SRC_SEL_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [lcgs_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [lcgs_pkg::DATA_W-1:0] pwdata_i,
    output logic [lcgs_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // candidate sources from outside the clock domain
    input wire logic [NUM_SRC-1:0] src_i,
    // gate outputs towards the cell function
    output logic [NUM_GATES-1:0] gate_out_o
);

    // ***************************************************************
    // decode helper
    // ***************************************************************
    function automatic logic word_hit(input logic [lcgs_pkg::ADDR_W-1:0] addr,
                                      input logic [lcgs_pkg::ADDR_W-1:0] base,
                                      input int idx);
        logic [lcgs_pkg::ADDR_W-1:0] target;
        target = base + lcgs_pkg::ADDR_W'(idx) * lcgs_pkg::OFS_STRIDE;
        return addr == target;
    endfunction

    // ***************************************************************
    // reset synchroniser
    // ***************************************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    assign rst_n = rst_sync_ff[1];

    // ***************************************************************
    // source synchroniser
    // ***************************************************************
    logic [NUM_SRC-1:0] src_meta_ff;
    logic [NUM_SRC-1:0] src_sync_ff;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_meta_ff <= '0;
            src_sync_ff <= '0;
        end
        else
        begin
            src_meta_ff <= src_i;
            src_sync_ff <= src_meta_ff;
        end
    end

    // ***************************************************************
    // apb decode
    // ***************************************************************
    lcgs_pkg::lcgs_apb_req_t req;
    logic setup_phase;
    logic access_done;
    logic wr_stb;
    logic rd_setup;

    logic [NUM_GATES-1:0] gate_en_hit;
    logic [NUM_DATA-1:0] src_sel_hit;
    logic pol_hit;
    logic status_hit;
    logic mapped;
    logic [NUM_GATES-1:0] gate_en_wr;
    logic [NUM_DATA-1:0] src_sel_wr;
    logic pol_wr;

    assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};
    assign setup_phase = psel_i & ~penable_i;
    assign access_done = psel_i & penable_i & pready_o;
    assign wr_stb = access_done & req.write;
    assign rd_setup = setup_phase & ~req.write;
    assign pol_hit = word_hit(req.addr, lcgs_pkg::OFS_POLARITY, 0);
    assign status_hit = word_hit(req.addr, lcgs_pkg::OFS_GATE_STATUS, 0);
    assign mapped = (|gate_en_hit) | (|src_sel_hit) | pol_hit | status_hit;

    // writes land only at the edge that closes the access phase;
    // the status word has no write strobe, so writes to it fall away
    assign gate_en_wr = gate_en_hit & {NUM_GATES{wr_stb}};
    assign src_sel_wr = src_sel_hit & {NUM_DATA{wr_stb}};
    assign pol_wr = pol_hit & wr_stb;

    // ***************************************************************
    // register storage and read words
    // ***************************************************************
    logic [lcgs_pkg::EN_W-1:0] gate_en_ff [NUM_GATES];
    logic [lcgs_pkg::EN_W-1:0] nxt_gate_en [NUM_GATES];
    logic [SEL_W-1:0] src_sel_ff [NUM_DATA];
    logic [SEL_W-1:0] nxt_src_sel [NUM_DATA];
    logic [NUM_GATES-1:0] polarity_ff;
    logic [NUM_GATES-1:0] nxt_polarity;

    logic [lcgs_pkg::DATA_W-1:0] rd_gate [NUM_GATES];
    logic [lcgs_pkg::DATA_W-1:0] rd_src [NUM_DATA];
    logic [lcgs_pkg::DATA_W-1:0] gate_acc [NUM_GATES+1];
    logic [lcgs_pkg::DATA_W-1:0] src_acc [NUM_DATA+1];

    // read words are or-ed together; at most one hit is high
    assign gate_acc[0] = '0;
    assign src_acc[0] = '0;

    // ***************************************************************
    // gate enable registers
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_GATES; g++)
        begin : g_gate_reg
            assign gate_en_hit[g] = word_hit(req.addr, lcgs_pkg::OFS_GATE_EN_BASE, g);

            // one register per gate, same bit arrangement for all four
            assign nxt_gate_en[g] = gate_en_wr[g] ?
                req.wdata[lcgs_pkg::EN_W-1:0] : gate_en_ff[g];

            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    gate_en_ff[g] <= lcgs_pkg::RST_GATE_EN;
                else
                    gate_en_ff[g] <= nxt_gate_en[g];
            end

            assign rd_gate[g] = gate_en_hit[g] ?
                {{(lcgs_pkg::DATA_W-lcgs_pkg::EN_W){1'h0}}, gate_en_ff[g]} : '0;
            assign gate_acc[g+1] = gate_acc[g] | rd_gate[g];
        end
    endgenerate

    // ***************************************************************
    // source select registers
    // ***************************************************************
    genvar d;
    generate
        for (d = 0; d < NUM_DATA; d++)
        begin : g_sel_reg
            // each data input keeps its own selector
            assign src_sel_hit[d] = word_hit(req.addr, lcgs_pkg::OFS_SRC_SEL_BASE, d);
            assign nxt_src_sel[d] = src_sel_wr[d] ? req.wdata[SEL_W-1:0] : src_sel_ff[d];

            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    src_sel_ff[d] <= lcgs_pkg::RST_SRC_SEL;
                else
                    src_sel_ff[d] <= nxt_src_sel[d];
            end

            assign rd_src[d] = src_sel_hit[d] ? {{(lcgs_pkg::DATA_W-SEL_W){1'h0}}, src_sel_ff[d]} : '0;
            assign src_acc[d+1] = src_acc[d] | rd_src[d];
        end
    endgenerate

    // ***************************************************************
    // polarity register
    // ***************************************************************
    // bit g inverts gate g+1 on its way to the cell function
    assign nxt_polarity = pol_wr ? req.wdata[lcgs_pkg::POL_LSB +: NUM_GATES] : polarity_ff;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            polarity_ff <= lcgs_pkg::RST_POLARITY;
        else
            polarity_ff <= nxt_polarity;
    end

    // ***************************************************************
    // data input selection
    // ***************************************************************
    logic [NUM_DATA-1:0] data_in;

    // only synchronised candidates reach the gates
    generate
        for (d = 0; d < NUM_DATA; d++)
        begin : g_data
            lcgs_src_sel #(
                .NUM_SRC(NUM_SRC),
                .SEL_W(SEL_W)
            ) i_lcgs_src_sel (
                .src_i(src_sync_ff),
                .sel_i(src_sel_ff[d]),
                .data_o(data_in[d])
            );
        end
    endgenerate

    // ***************************************************************
    // gates
    // ***************************************************************
    lcgs_pkg::lcgs_gate_cfg_t gate_cfg [NUM_GATES];
    logic [NUM_GATES-1:0] gate_comb;

    generate
        for (g = 0; g < NUM_GATES; g++)
        begin : g_gate
            assign gate_cfg[g] = '{en: gate_en_ff[g], pol: polarity_ff[g]};

            lcgs_gate #(
                .NUM_DATA(NUM_DATA)
            ) i_lcgs_gate (
                .data_i(data_in),
                .cfg_i(gate_cfg[g]),
                .gate_o(gate_comb[g])
            );
        end
    endgenerate

    // ***************************************************************
    // read mux
    // ***************************************************************
    logic [lcgs_pkg::DATA_W-1:0] rd_pol;
    logic [lcgs_pkg::DATA_W-1:0] rd_status;
    logic [lcgs_pkg::DATA_W-1:0] rd_data;

    assign rd_pol = pol_hit ?
        {{(lcgs_pkg::DATA_W-NUM_GATES){1'h0}}, polarity_ff} << lcgs_pkg::POL_LSB : '0;
    // status shows the registered gate outputs, as the cell function sees them
    assign rd_status = status_hit ?
        {{(lcgs_pkg::DATA_W-NUM_GATES){1'h0}}, gate_out_o} << lcgs_pkg::STATUS_LSB : '0;
    assign rd_data = gate_acc[NUM_GATES] | src_acc[NUM_DATA] | rd_pol | rd_status;

    // ***************************************************************
    // apb answer and gate outputs
    // ***************************************************************
    logic nxt_pready;
    logic nxt_pslverr;
    logic [lcgs_pkg::DATA_W-1:0] nxt_prdata;
    logic [NUM_GATES-1:0] nxt_gate_out;

    // zero wait states: the answer stands for the one access cycle only
    assign nxt_pready = setup_phase;
    // unmapped addresses answer with an error and no data
    assign nxt_pslverr = setup_phase & ~mapped;
    assign nxt_prdata = rd_setup ? rd_data : '0;
    assign nxt_gate_out = gate_comb;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pready_o <= 1'h0;
        else
            pready_o <= nxt_pready;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pslverr_o <= 1'h0;
        else
            pslverr_o <= nxt_pslverr;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            prdata_o <= '0;
        else
            prdata_o <= nxt_prdata;
    end

    // gate outputs leave through a flip-flop like every other output
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            gate_out_o <= '0;
        else
            gate_out_o <= nxt_gate_out;
    end

endmodule // lcgs_top

// file: src/lcgs_pkg.sv
package lcgs_pkg;

    // ***************************************************************
    // sizes
    // ***************************************************************
    localparam int NUM_GATES = 4;
    localparam int NUM_DATA = 4;
    localparam int SRC_SEL_W = 5;
    localparam int NUM_SRC = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EN_W = 8;

    // ***************************************************************
    // register byte offsets (one aligned word each)
    // ***************************************************************
    localparam logic [7:0] OFS_GATE_EN_BASE = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h10;
    localparam logic [7:0] OFS_SRC_SEL_BASE = 8'h14;
    localparam logic [7:0] OFS_GATE_STATUS = 8'h24;
    localparam logic [7:0] OFS_STRIDE = 8'h04;

    // ***************************************************************
    // field positions
    // ***************************************************************
    // enable bit 2*d+1 takes true copy of data input d+1, bit 2*d the inverted copy
    localparam int EN_TRUE_OFS = 1;
    localparam int EN_INV_OFS = 0;
    localparam int POL_LSB = 0;
    localparam int STATUS_LSB = 0;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [7:0] RST_GATE_EN = 8'h00;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [4:0] RST_SRC_SEL = 5'h00;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic [EN_W-1:0] en;
        logic pol;
    } lcgs_gate_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [DATA_W-1:0] wdata;
    } lcgs_apb_req_t;

endpackage

// file: src/lcgs_src_sel.sv
// picks one of the candidate sources for one data input
module lcgs_src_sel #(
    parameter int NUM_SRC = 32,
    parameter int SEL_W = 5
) (
    // candidates
    input wire logic [NUM_SRC-1:0] src_i,
    // selection
    input wire logic [SEL_W-1:0] sel_i,
    // chosen data input
    output logic data_o
);

    assign data_o = src_i[sel_i];

endmodule // lcgs_src_sel

// file: src/lcgs_gate.sv
// one gate: or of the enabled true/inverted copies, then polarity
module lcgs_gate #(
    parameter int NUM_DATA = 4
) (
    // data inputs 1..NUM_DATA in bits 0..NUM_DATA-1
    input wire logic [NUM_DATA-1:0] data_i,
    // enables and polarity
    input wire lcgs_pkg::lcgs_gate_cfg_t cfg_i,
    // gate result after polarity
    output logic gate_o
);

    logic [2*NUM_DATA-1:0] copies;
    logic gate_raw;

    genvar d;
    generate
        for (d = 0; d < NUM_DATA; d++)
        begin : g_copy
            assign copies[2*d+lcgs_pkg::EN_TRUE_OFS] = data_i[d];
            assign copies[2*d+lcgs_pkg::EN_INV_OFS] = ~data_i[d];
        end
    endgenerate

    // disabled copies drop out; nothing enabled gives zero
    assign gate_raw = |(copies & cfg_i.en);
    assign gate_o = gate_raw ^ cfg_i.pol;

endmodule // lcgs_gate

// file: tb/lcgs_top_chk.sv
module lcgs_top_chk #(
    parameter int NUM_GATES = 4,
    parameter int NUM_SRC = 32
) (
    // clock, reset and apb
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // cell side
    input wire logic [NUM_SRC-1:0] src_i,
    input wire logic [NUM_GATES-1:0] gate_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // shadow model
    // ****************
    logic [7:0] en_ff [4];
    logic [3:0] pol_ff;
    logic [4:0] sel_ff [4];
    logic [NUM_SRC-1:0] s1_ff, s2_ff;
    logic [3:0] exp_ff, nxt_exp;
    logic [2:0] up_ff;
    logic [31:0] rd_exp;
    wire setup = psel_i && !penable_i;
    wire wr = psel_i && penable_i && pready_o && pwrite_i;
    wire [3:0] idx = paddr_i[5:2];
    wire [3:0] sidx = idx - 4'h1;
    wire mapped = paddr_i <= 8'h24 && paddr_i[1:0] == 2'h0;
    always_comb
    begin
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 4; i++)
            m[2*i+:2] = {s2_ff[sel_ff[i]], !s2_ff[sel_ff[i]]};
        for (int g = 0; g < 4; g++)
            nxt_exp[g] = |(en_ff[g] & m) ^ pol_ff[g];
        rd_exp = 32'h0;
        if (mapped && idx < 4'h4)
            rd_exp = {24'h0, en_ff[idx[1:0]]};
        else if (mapped && idx == 4'h4)
            rd_exp = {28'h0, pol_ff};
        else if (mapped && idx < 4'h9)
            rd_exp = {27'h0, sel_ff[sidx[1:0]]};
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            en_ff <= '{default: 8'h00};
            sel_ff <= '{default: 5'h00};
            {pol_ff, s1_ff, s2_ff, exp_ff, up_ff} <= '0;
        end
        else
        begin
            s1_ff <= src_i;
            s2_ff <= s1_ff;
            exp_ff <= nxt_exp;
            up_ff <= up_ff + {2'h0, up_ff != 3'h7};
            if (wr && mapped && idx < 4'h4)
                en_ff[idx[1:0]] <= pwdata_i[7:0];
            if (wr && mapped && idx == 4'h4)
                pol_ff <= pwdata_i[3:0];
            if (wr && mapped && idx > 4'h4 && idx < 4'h9)
                sel_ff[sidx[1:0]] <= pwdata_i[4:0];
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_after_setup: assert property (setup |=> pready_o)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_err_unmapped: assert property (setup |=> pslverr_o == !$past(mapped))
        else $error("wrong error response");
    a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    a_read_back: assert property (
        setup && !pwrite_i && paddr_i != 8'h24 |=> prdata_o == $past(rd_exp))
        else $error("register read differs");
    a_gate_func: assert property (
        up_ff == 3'h7 |-> gate_out_o == exp_ff)
        else $error("gate output differs");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> (gate_out_o == '0 && !pready_o) [*2])
        else $error("outputs active after reset");
    c_write: cover property (wr);
    c_error: cover property (pslverr_o);
    c_gate_move: cover property ($changed(gate_out_o));
endmodule // lcgs_top_chk

bind lcgs_top lcgs_top_chk #(.NUM_GATES(NUM_GATES), .NUM_SRC(NUM_SRC)) i_lcgs_top_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .src_i(src_i), .gate_out_o(gate_out_o));

// file: tb/lcgs_tb_top.sv
module lcgs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] src_i = 32'h0;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, err;
    logic [3:0] gate_out_o;
    int n_errors = 0;
    int num_checks = 0;
    lcgs_top i_lcgs_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .src_i(src_i), .gate_out_o(gate_out_o));
    always #25 clk_i = ~clk_i;
    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 16);
        chk({31'h0, pready_o}, 32'h1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, e});
    endtask
    function automatic logic gexp(input logic [7:0] en, input logic p, input logic [3:0] d);
        gexp = p;
        for (int i = 0; i < 4; i++)
            if ((en[2*i+1] && d[i]) || (en[2*i] && !d[i]))
                gexp = !p;
    endfunction
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        for (int a = 0; a < 10; a++)
            rchk(8'(a * 4), 32'h0, 1'b0);
        apb(1'b1, 8'h24, 32'hf);
        rchk(8'h24, 32'h0, 1'b0);
        apb(1'b1, 8'h28, 32'hff);
        chk({31'h0, err}, 32'h1);
        rchk(8'h02, 32'h0, 1'b1);
    endtask
    task automatic t_regs();
        logic [31:0] v [2] = '{32'hffff_ffff, 32'ha5a5_a5a5};
        logic [31:0] m;
        for (int k = 0; k < 2; k++)
            for (int i = 0; i < 9; i++)
            begin
                m = i < 4 ? 32'hff : (i == 4 ? 32'hf : 32'h1f);
                apb(1'b1, 8'(i * 4), v[k]);
                rchk(8'(i * 4), v[k] & m, 1'b0);
            end
    endtask
    task automatic t_gates();
        logic [7:0] ev [4];
        logic [3:0] e;
        logic [31:0] s;
        for (int d = 0; d < 4; d++)
            apb(1'b1, 8'(20 + 4 * d), 32'(7 * d + 3));
        for (int k = 0; k < 10; k++)
        begin
            for (int g = 0; g < 4; g++)
            begin
                ev[g] = k < 8 ? 8'h01 << ((k + 2 * g) % 8) : (k == 8 ? 8'h00 : 8'h0a << (2 * g));
                apb(1'b1, 8'(4 * g), {24'h0, ev[g]});
            end
            apb(1'b1, 8'h10, 32'(k));
            for (int p = 0; p < 16; p++)
            begin
                s = 32'h5555_aaaa;
                for (int d = 0; d < 4; d++)
                    s[7 * d + 3] = p[d];
                src_i <= s;
                repeat (5) @(posedge clk_i);
                for (int g = 0; g < 4; g++)
                    e[g] = gexp(ev[g], k[g], p[3:0]);
                chk({28'h0, gate_out_o}, {28'h0, e});
                rchk(8'h24, {28'h0, e}, 1'b0);
            end
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_regs();
        t_gates();
        report_and_stop();
    end
    initial
    begin
        #(50ns * 20000);
        n_errors++;
        report_and_stop();
    end
endmodule // lcgs_tb_top
